/* iora_pkg.sv */
// Package for the interrupt controller register front end.
// Assumes one clock domain and a host that issues single 32-bit accesses.
package iora_pkg;

  // ==========================================================
  // Configuration header offsets
  localparam logic [7:0] IORA_CFG_CMD = 8'h04;
  localparam logic [7:0] IORA_CFG_CLASS = 8'h08;
  localparam logic [7:0] IORA_CFG_BAR_LO = 8'h10;
  localparam logic [7:0] IORA_CFG_BAR_HI = 8'h14;

  // ==========================================================
  // Command word fields and constant parts
  localparam int IORA_CMD_MEM_BIT = 1;
  localparam int IORA_CMD_MST_BIT = 2;
  localparam logic [31:0] IORA_CMD_FIXED = 32'h0200_0000;
  localparam logic [23:0] IORA_CLASS_CODE = 24'h08_0010;
  // Revision code, value arbitrary
  localparam logic [7:0] IORA_REVISION = 8'hA5;

  // ==========================================================
  // Base address register layout
  localparam int IORA_BAR_LSB = 12;
  localparam logic [11:0] IORA_BAR_LOW_BITS = 12'h004;
  localparam logic [51:0] IORA_BAR_RESET = 52'h0_0000_0000_0000;

  // ==========================================================
  // Memory window offsets
  localparam logic [11:0] IORA_WIN_SELECT = 12'h000;
  localparam logic [11:0] IORA_WIN_DATA = 12'h010;

  // ==========================================================
  // Internal indices and fields
  localparam logic [7:0] IORA_IDX_ID = 8'h00;
  localparam logic [7:0] IORA_IDX_VER = 8'h01;
  localparam logic [7:0] IORA_IDX_RTE_BASE = 8'h10;
  localparam int IORA_NUM_SRC = 10;
  localparam logic [7:0] IORA_MAX_ENTRY = 8'h09;
  // Implementation version code, value arbitrary
  localparam logic [7:0] IORA_IMPL_VERSION = 8'h5A;
  localparam int IORA_ID_LSB = 24;
  localparam int IORA_RTE_MASK_BIT = 16;
  localparam int IORA_RTE_POL_BIT = 13;
  localparam logic [63:0] IORA_RTE_RESET = 64'h0000_0000_0001_0000;
  // Writable bits of an entry: 63:32, 16, 15, 13, 11:0
  localparam logic [63:0] IORA_RTE_WMASK = 64'hFFFF_FFFF_0001_AFFF;

  // ==========================================================
  // Request carriers
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } iora_cfg_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [63:0] addr;
    logic [31:0] wdata;
  } iora_mem_req_t;

endpackage

/* iora_top.sv */
// Configuration header, memory window and indirect registers of the
// interrupt controller, plus message launch for its ten sources.
// Assumes requests are synchronous to i_mclk and one cycle each.
//
// Contract
// - Messages only while master enable set
// - Window decoded only while memory enable set
// - Base address bits 63:12 writable, reset zero
// - Base address low bits read constant 004h
// - Internal registers reached via select/window only
// - Select holds 8-bit index, upper bits zero
// - Window access hits register named by index
// - Index 00h holds 4-bit identifier, bits 27:24
// - Version word bits 23:16 read 09h
// - Exactly ten sources, one entry each
// - Version bits 7:0 fixed code, bits 31:24 and 15:8 zero
// - Entry mask bit 16 resets set, blocks
// - Function present only in two-function mode
`timescale 1ns/1ns
module iora_top
  import iora_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Bridge mode
  input wire logic i_two_function_mode,
  // Configuration access
  input wire iora_cfg_req_t i_cfg_req,
  output logic o_cfg_claim,
  output logic o_cfg_rvalid,
  output logic [31:0] o_cfg_rdata,
  // Memory access
  input wire iora_mem_req_t i_mem_req,
  output logic o_mem_claim,
  output logic o_mem_rvalid,
  output logic [31:0] o_mem_rdata,
  // Interrupt sources
  input wire logic [IORA_NUM_SRC-1:0] i_irq_src,
  // Interrupt message out
  output logic o_msg_valid,
  output logic [3:0] o_msg_source,
  output logic [63:0] o_msg_entry
);

  // ==========================================================
  // State
  logic mem_en_r; // Memory decode enable
  logic mst_en_r; // Message mastering enable
  logic [51:0] bar_r; // Window base, bits 63:12
  logic [7:0] sel_r; // Indirect index
  logic [3:0] id_r; // Controller identifier
  logic [63:0] rte_r [IORA_NUM_SRC]; // Redirection entries
  logic [IORA_NUM_SRC-1:0] src_q_r; // Previous asserted levels
  logic [IORA_NUM_SRC-1:0] pend_r; // Edges waiting to be sent

  // Internal index to entry number and half; returns valid flag
  function automatic logic rte_decode(input logic [7:0] idx,
                                      output logic [3:0] ent,
                                      output logic hi);
    logic [7:0] off;
    off = idx - IORA_IDX_RTE_BASE;
    ent = off[4:1];
    hi = off[0];
    return (idx >= IORA_IDX_RTE_BASE) &&
           (off < 8'(2 * IORA_NUM_SRC));
  endfunction

  // ==========================================================
  // Decode
  logic mem_hit; // Access lands in our window
  logic win_sel; // Select register hit
  logic win_dat; // Data window hit
  logic [3:0] ent; // Entry addressed by index
  logic ent_hi; // Upper half of entry
  logic ent_ok; // Index names an entry
  logic [31:0] ind_rd; // Indirect read value

  // Window decode gated by mode and memory enable
  always_comb begin
    mem_hit = i_mem_req.valid && i_two_function_mode &&
              mem_en_r &&
              (i_mem_req.addr[63:IORA_BAR_LSB] == bar_r);
    win_sel = mem_hit &&
              (i_mem_req.addr[11:0] == IORA_WIN_SELECT);
    win_dat = mem_hit &&
              (i_mem_req.addr[11:0] == IORA_WIN_DATA);
  end

  // Indirect read mux
  always_comb begin
    ind_rd = 32'h0000_0000;
    ent_ok = rte_decode(sel_r, ent, ent_hi);
    if (sel_r == IORA_IDX_ID) begin
      ind_rd[IORA_ID_LSB+3:IORA_ID_LSB] = id_r;
    end else if (sel_r == IORA_IDX_VER) begin
      ind_rd = {8'h00, IORA_MAX_ENTRY, 8'h00,
                IORA_IMPL_VERSION};
    end else if (ent_ok) begin
      ind_rd = ent_hi ? rte_r[ent][63:32] : rte_r[ent][31:0];
    end
  end

  assign o_mem_claim = mem_hit;
  assign o_cfg_claim = i_cfg_req.valid && i_two_function_mode;

  // ==========================================================
  // Configuration header writes
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mem_en_r <= 1'b0;
      mst_en_r <= 1'b0;
      bar_r <= IORA_BAR_RESET;
    end else if (o_cfg_claim && i_cfg_req.write) begin
      case (i_cfg_req.addr)
        IORA_CFG_CMD: begin
          mem_en_r <= i_cfg_req.wdata[IORA_CMD_MEM_BIT];
          mst_en_r <= i_cfg_req.wdata[IORA_CMD_MST_BIT];
        end
        IORA_CFG_BAR_LO: begin
          bar_r[19:0] <= i_cfg_req.wdata[31:12];
        end
        IORA_CFG_BAR_HI: begin
          bar_r[51:20] <= i_cfg_req.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Configuration read answer, one cycle later
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg_rvalid <= 1'b0;
      o_cfg_rdata <= 32'h0000_0000;
    end else begin
      o_cfg_rvalid <= o_cfg_claim && !i_cfg_req.write;
      if (o_cfg_claim && !i_cfg_req.write) begin
        case (i_cfg_req.addr)
          IORA_CFG_CMD: o_cfg_rdata <= IORA_CMD_FIXED |
            {29'h0, mst_en_r, mem_en_r, 1'b0};
          IORA_CFG_CLASS: o_cfg_rdata <= {IORA_CLASS_CODE, IORA_REVISION};
          IORA_CFG_BAR_LO: begin
            o_cfg_rdata <= {bar_r[19:0], IORA_BAR_LOW_BITS};
          end
          IORA_CFG_BAR_HI: o_cfg_rdata <= bar_r[51:20];
          default: o_cfg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Select and identifier writes
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sel_r <= 8'h00;
      id_r <= 4'h0;
    end else if (i_mem_req.write) begin
      if (win_sel) begin
        sel_r <= i_mem_req.wdata[7:0];
      end else if (win_dat && sel_r == IORA_IDX_ID) begin
        id_r <= i_mem_req.wdata[IORA_ID_LSB+3:IORA_ID_LSB];
      end
    end
  end

  // Redirection entry writes through the data window
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < IORA_NUM_SRC; i++) begin
        rte_r[i] <= IORA_RTE_RESET;
      end
    end else if (win_dat && i_mem_req.write && ent_ok) begin
      if (ent_hi) begin
        rte_r[ent][63:32] <= i_mem_req.wdata;
      end else begin
        rte_r[ent][31:0] <= (i_mem_req.wdata & IORA_RTE_WMASK[31:0]) |
                            (rte_r[ent][31:0] & ~IORA_RTE_WMASK[31:0]);
      end
    end
  end

  // Memory read answer, one cycle later
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mem_rvalid <= 1'b0;
      o_mem_rdata <= 32'h0000_0000;
    end else begin
      o_mem_rvalid <= mem_hit && !i_mem_req.write;
      if (mem_hit && !i_mem_req.write) begin
        if (win_sel) begin
          o_mem_rdata <= {24'h00_0000, sel_r};
        end else if (win_dat) begin
          o_mem_rdata <= ind_rd;
        end else begin
          o_mem_rdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================
  // Source edge capture
  logic [IORA_NUM_SRC-1:0] src_act; // Levels after polarity
  logic [IORA_NUM_SRC-1:0] src_edge; // Newly asserted, unmasked
  logic [IORA_NUM_SRC-1:0] send_oh; // Lowest pending one-hot
  logic [3:0] send_idx; // Lowest pending number
  logic [IORA_NUM_SRC-1:0] pend_ok; // Pending and still unmasked

  always_comb begin
    send_idx = 4'h0;
    send_oh = '0;
    for (int i = 0; i < IORA_NUM_SRC; i++) begin
      src_act[i] = i_irq_src[i] ^ rte_r[i][IORA_RTE_POL_BIT];
      src_edge[i] = src_act[i] && !src_q_r[i] &&
                    !rte_r[i][IORA_RTE_MASK_BIT];
      // Masking after capture still blocks the send
      pend_ok[i] = pend_r[i] && !rte_r[i][IORA_RTE_MASK_BIT];
    end
    for (int i = IORA_NUM_SRC - 1; i >= 0; i--) begin
      if (pend_ok[i]) begin
        send_idx = 4'(i);
        send_oh = '0;
        send_oh[i] = 1'b1;
      end
    end
  end

  // Pending flags; a new edge wins over the send clear
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      src_q_r <= '0;
      pend_r <= '0;
    end else begin
      src_q_r <= src_act;
      pend_r <= (pend_ok & ~((mst_en_r && i_two_function_mode) ?
                 send_oh : '0)) | src_edge;
    end
  end

  // Message launch, one per cycle
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_msg_valid <= 1'b0;
      o_msg_source <= 4'h0;
      o_msg_entry <= 64'h0;
    end else begin
      o_msg_valid <= mst_en_r && i_two_function_mode && |pend_ok;
      if (mst_en_r && i_two_function_mode && |pend_ok) begin
        o_msg_source <= send_idx;
        o_msg_entry <= rte_r[send_idx];
      end
    end
  end

endmodule

/* iora_properties.sv */
// Port checker for the register front end.
// Assumes it is bound onto iora_top.
`timescale 1ns/1ns
module iora_properties
  import iora_pkg::*;
(
  // Clock, reset, mode
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_two_function_mode,
  // Buses
  input wire iora_cfg_req_t i_cfg_req,
  input wire logic o_cfg_claim,
  input wire logic o_cfg_rvalid,
  input wire logic [31:0] o_cfg_rdata,
  input wire iora_mem_req_t i_mem_req,
  input wire logic o_mem_claim,
  input wire logic o_mem_rvalid,
  input wire logic [31:0] o_mem_rdata,
  // Messages
  input wire logic o_msg_valid,
  input wire logic [3:0] o_msg_source,
  input wire logic [63:0] o_msg_entry
);
  // ==========================================================
  // Shadow state
  logic mem_r, mst_r; // Enables
  logic [51:0] bar_r; // Window base
  logic [7:0] sel_r; // Index
  wire cfg_wr = o_cfg_claim && i_cfg_req.write;
  // Command shadow
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      {mst_r, mem_r} <= 2'h0;
    end else if (cfg_wr && i_cfg_req.addr == IORA_CFG_CMD) begin
      {mst_r, mem_r} <= i_cfg_req.wdata[2:1];
    end
  end
  // Base shadow
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bar_r <= '0;
    end else if (cfg_wr && i_cfg_req.addr == IORA_CFG_BAR_LO) begin
      bar_r[19:0] <= i_cfg_req.wdata[31:12];
    end else if (cfg_wr && i_cfg_req.addr == IORA_CFG_BAR_HI) begin
      bar_r[51:20] <= i_cfg_req.wdata;
    end
  end
  // Index shadow
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sel_r <= 8'h00;
    end else if (o_mem_claim && i_mem_req.write &&
                 i_mem_req.addr[11:0] == IORA_WIN_SELECT) begin
      sel_r <= i_mem_req.wdata[7:0];
    end
  end
  // ==========================================================
  // Properties
  sequence cfg_rd_s(a);
    o_cfg_claim && !i_cfg_req.write && i_cfg_req.addr == a;
  endsequence
  sequence mem_rd_s;
    o_mem_claim && !i_mem_req.write;
  endsequence
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  a_cmd_read: assert property (cfg_rd_s(IORA_CFG_CMD) |=>
    o_cfg_rvalid && o_cfg_rdata == (IORA_CMD_FIXED | {mst_r, mem_r, 1'b0}))
    else $error("command word readback wrong");
  a_bar_low: assert property (cfg_rd_s(IORA_CFG_BAR_LO) |=>
    o_cfg_rvalid && o_cfg_rdata == {bar_r[19:0], 12'h004})
    else $error("base low dword wrong");
  a_bar_high: assert property (cfg_rd_s(IORA_CFG_BAR_HI) |=>
    o_cfg_rdata == bar_r[51:20])
    else $error("base high dword wrong");
  a_mem_decode: assert property (o_mem_claim == (i_mem_req.valid &&
    mem_r && i_two_function_mode && i_mem_req.addr[63:12] == bar_r))
    else $error("window decode wrong");
  a_mem_answer: assert property (mem_rd_s |=> o_mem_rvalid)
    else $error("window read unanswered");
  a_select_read: assert property (mem_rd_s ##0
    i_mem_req.addr[11:0] == IORA_WIN_SELECT |=> o_mem_rdata == {24'h0, sel_r})
    else $error("select readback wrong");
  a_msg_master: assert property (o_msg_valid |-> $past(mst_r))
    else $error("message while master disabled");
  a_msg_unmasked: assert property (o_msg_valid |->
    !o_msg_entry[16] && o_msg_source < 4'hA)
    else $error("masked or bad source sent");
  a_mode_absent: assert property (!i_two_function_mode |->
    !o_cfg_claim && !o_mem_claim)
    else $error("claim while function absent");
endmodule
bind iora_top iora_properties chk (.i_mclk, .i_sys_rst, .i_two_function_mode,
  .i_cfg_req, .o_cfg_claim, .o_cfg_rvalid, .o_cfg_rdata, .i_mem_req,
  .o_mem_claim, .o_mem_rvalid, .o_mem_rdata, .o_msg_valid, .o_msg_source,
  .o_msg_entry);

/* iora_host.sv */
// Host model issuing configuration and memory cycles.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ns
module iora_host
  import iora_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Requests
  output iora_cfg_req_t o_cfg_req,
  output iora_mem_req_t o_mem_req,
  // Answers
  input wire logic i_cfg_rvalid,
  input wire logic [31:0] i_cfg_rdata,
  input wire logic i_mem_rvalid,
  input wire logic [31:0] i_mem_rdata
);
  logic [51:0] base = '0; // Window base the host programmed
  initial begin
    o_cfg_req = '0;
    o_mem_req = '0;
  end
  // Config cycle; no answer reads as all ones; released lines inverted
  task automatic cfg(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge i_mclk);
    #1;
    o_cfg_req = '{1'b1, w, a, d};
    @(posedge i_mclk);
    #1;
    r = i_cfg_rvalid ? i_cfg_rdata : 32'hFFFF_FFFF;
    o_cfg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Memory cycle inside the programmed window
  task automatic mem(input logic w, input logic [11:0] off,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge i_mclk);
    #1;
    o_mem_req = '{1'b1, w, {base, off}, d};
    @(posedge i_mclk);
    #1;
    r = i_mem_rvalid ? i_mem_rdata : 32'hFFFF_FFFF;
    o_mem_req = '{1'b0, 1'b0, ~{base, off}, ~d};
  endtask
endmodule

/* ioapic_register_access_bench.sv */
// Self-checking bench for the register front end.
// Assumes the host model drives both buses.
`timescale 1ns/1ns
module ioapic_register_access_bench
  import iora_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_two_function_mode = 1'b1;
  logic [IORA_NUM_SRC-1:0] i_irq_src = '0;
  iora_cfg_req_t i_cfg_req;
  iora_mem_req_t i_mem_req;
  logic o_cfg_claim, o_cfg_rvalid, o_mem_claim, o_mem_rvalid, o_msg_valid;
  logic [31:0] o_cfg_rdata, o_mem_rdata, r;
  logic [3:0] o_msg_source;
  logic [63:0] o_msg_entry;
  int fail_count = 0;
  int n_compared = 0;
  int cnt;
  localparam logic [3:0] CTRL_ID = 4'h9; // Unique per controller
  iora_top dut (.i_mclk, .i_sys_rst, .i_two_function_mode, .i_cfg_req,
    .o_cfg_claim, .o_cfg_rvalid, .o_cfg_rdata, .i_mem_req, .o_mem_claim,
    .o_mem_rvalid, .o_mem_rdata, .i_irq_src, .o_msg_valid, .o_msg_source,
    .o_msg_entry);
  iora_host host (.i_mclk, .o_cfg_req(i_cfg_req), .o_mem_req(i_mem_req),
    .i_cfg_rvalid(o_cfg_rvalid), .i_cfg_rdata(o_cfg_rdata),
    .i_mem_rvalid(o_mem_rvalid), .i_mem_rdata(o_mem_rdata));
  initial begin
    forever #2 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Indirect write and read, select then data
  task automatic iwr(input logic [7:0] i, input logic [31:0] d);
    host.mem(1'b1, IORA_WIN_SELECT, {24'h0, i}, r);
    host.mem(1'b1, IORA_WIN_DATA, d, r);
  endtask
  task automatic ird(input logic [7:0] i, input logic [31:0] e);
    host.mem(1'b1, IORA_WIN_SELECT, {24'h0, i}, r);
    host.mem(1'b0, IORA_WIN_DATA, 32'h0, r);
    chk(r, e);
  endtask
  // Count messages over n cycles
  task automatic watch(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge i_mclk);
      #1;
      if (o_msg_valid === 1'b1) begin
        cnt++;
        chk({28'h0, o_msg_source}, 32'h3);
        chk(o_msg_entry[31:0], 32'h0000_0030);
      end
    end
  endtask
  task automatic t_header;
    host.cfg(1'b0, IORA_CFG_CMD, 32'h0, r);
    chk(r, 32'h0200_0000);
    host.cfg(1'b0, IORA_CFG_CLASS, 32'h0, r);
    chk(r, {IORA_CLASS_CODE, IORA_REVISION});
    host.cfg(1'b0, IORA_CFG_BAR_LO, 32'h0, r);
    chk(r, 32'h0000_0004);
    host.cfg(1'b1, IORA_CFG_BAR_LO, 32'h2345_6FFF, r);
    host.cfg(1'b0, IORA_CFG_BAR_LO, 32'h0, r);
    chk(r, 32'h2345_6004);
    host.cfg(1'b1, IORA_CFG_BAR_HI, 32'h1, r);
    host.cfg(1'b0, IORA_CFG_BAR_HI, 32'h0, r);
    chk(r, 32'h1);
    host.base = {32'h1, 20'h23456};
  endtask
  task automatic t_window;
    host.mem(1'b1, IORA_WIN_SELECT, 32'h33, r);
    host.mem(1'b0, IORA_WIN_SELECT, 32'h0, r);
    chk(r, 32'hFFFF_FFFF);
    host.cfg(1'b1, IORA_CFG_CMD, 32'h2, r);
    host.mem(1'b0, IORA_WIN_SELECT, 32'h0, r);
    chk(r, 32'h0);
    host.mem(1'b1, IORA_WIN_SELECT, 32'hFFFF_FF01, r);
    host.mem(1'b0, IORA_WIN_SELECT, 32'h0, r);
    chk(r, 32'h1);
    ird(8'h01, {16'h0009, 8'h00, IORA_IMPL_VERSION});
    iwr(8'h00, 32'hFFFF_FFFF);
    ird(8'h00, 32'h0F00_0000);
    iwr(8'h00, {4'h0, CTRL_ID, 24'h0});
    iwr(8'h02, 32'hFFFF_FFFF);
    ird(8'h02, 32'h0);
    ird(8'h22, 32'h0001_0000);
    ird(8'h24, 32'h0);
  endtask
  task automatic t_msg;
    iwr(8'h16, 32'h0000_0030);
    i_irq_src[3] = 1'b1;
    i_irq_src[5] = 1'b1;
    watch(8);
    chk(cnt, 32'h0);
    host.cfg(1'b1, IORA_CFG_CMD, 32'h6, r);
    watch(8);
    chk(cnt, 32'h1);
  endtask
  // Edge captured while master is off, then masked before enable
  task automatic t_mask;
    host.cfg(1'b1, IORA_CFG_CMD, 32'h2, r);
    i_irq_src[3] = 1'b0;
    watch(2);
    i_irq_src[3] = 1'b1;
    watch(2);
    iwr(8'h16, 32'h0001_0030);
    ird(8'h16, 32'h0001_0030);
    host.cfg(1'b1, IORA_CFG_CMD, 32'h6, r);
    watch(8);
    chk(cnt, 32'h0);
  endtask
  task automatic t_mode;
    i_two_function_mode = 1'b0;
    host.cfg(1'b0, IORA_CFG_CMD, 32'h0, r);
    chk(r, 32'hFFFF_FFFF);
    host.mem(1'b0, IORA_WIN_SELECT, 32'h0, r);
    chk(r, 32'hFFFF_FFFF);
  endtask
  initial begin
    repeat (5) @(posedge i_mclk);
    #1;
    i_sys_rst = 1'b0;
    t_header;
    t_window;
    t_msg;
    t_mask;
    t_mode;
    results;
  end
  initial begin
    #20000;
    fail_count++;
    results;
  end
endmodule
